// *** hw/rpc_top.sv ***
// Purpose: Power mode control register and power-on / supply monitor reset sequencing.
// Assumes: The analog monitor reports its comparator output; the pin pad resolves drive enables.
// Notes: reset only initialises the controller's own flops after power is first applied.
`timescale 1ns/1ps
module rpc_top
  import rpc_pkg::*;
#(
  parameter int POR_DELAY_CYCLES = RPC_POR_DELAY_CYCLES,
  parameter int PORT_WIDTH = 8
) (
  // Clock and power-on reset of the controller itself
  input wire logic clk,
  input wire logic reset,
  // Special function register port
  input wire rpc_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // Asynchronous sources
  input wire logic supply_above_threshold,
  input wire logic other_reset_req,
  input wire logic software_reset_req,
  // Core events
  input wire logic enabled_interrupt,
  input wire logic flash_write_attempt,
  // Core control
  output rpc_core_ctl_t core_ctl,
  output logic [15:0] pc_load_value,
  output logic regulator_calibrate,
  output logic wdt_tick,
  // Reset pin, active low, open drain
  output logic reset_pin_n_out,
  output logic reset_pin_n_oe,
  // Port defaults during reset
  output logic [PORT_WIDTH-1:0] port_latch_force,
  output logic port_force_en,
  output logic port_weak_pullup_en
);

  typedef enum logic [3:0] {
    RPC_ST_POWER_UP = 4'b0001,
    RPC_ST_POR_DELAY = 4'b0010,
    RPC_ST_RUN = 4'b0100,
    RPC_ST_HOLD = 4'b1000
  } rpc_state_t;

  logic [2:0] sync_raw;
  logic supply_ok;
  logic other_rst;
  logic sw_rst;

  rpc_sync #(.WIDTH(3)) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in({supply_above_threshold, other_reset_req, software_reset_req}),
    .sync_out(sync_raw)
  );

  assign supply_ok = sync_raw[2];
  assign other_rst = sync_raw[1];
  assign sw_rst = sync_raw[0];

  rpc_state_t state_q, state_d;
  logic [31:0] delay_q, delay_d;
  logic [5:0] flags_q, flags_d;
  logic stop_q, stop_d;
  logic idle_q, idle_d;
  logic por_flag_q, por_flag_d;
  logic mon_en_q, mon_en_d;
  logic mon_lvl_q, mon_lvl_d;
  logic mon_sel_q, mon_sel_d;
  logic pin_drive_q, pin_drive_d;
  logic flash_err_q, flash_err_d;
  logic [7:0] rdata_q, rdata_d;
  logic cal_q, cal_d;
  logic [3:0] wdt_cnt_q, wdt_cnt_d;
  logic wdt_tick_q, wdt_tick_d;
  logic mon_reset;
  logic any_reset;
  logic in_run;

  function automatic logic sfr_write(input rpc_sfr_req_t req, input logic [7:0] addr);
    sfr_write = req.wr && (req.addr == addr);
  endfunction

  // Selection is kept apart from the power-on flag, which a monitor reset clears while it must keep holding.
  assign mon_reset = mon_en_q && mon_sel_q && !supply_ok;
  assign any_reset = mon_reset || other_rst || sw_rst || flash_err_q;
  assign in_run = (state_q == RPC_ST_RUN);

  always_comb
  begin
    state_d = state_q;
    delay_d = delay_q;
    flags_d = flags_q;
    stop_d = stop_q;
    idle_d = idle_q;
    por_flag_d = por_flag_q;
    mon_en_d = mon_en_q;
    mon_lvl_d = mon_lvl_q;
    mon_sel_d = mon_sel_q;
    pin_drive_d = pin_drive_q;
    flash_err_d = 1'b0;
    cal_d = 1'b0;
    unique case (state_q)
      RPC_ST_POWER_UP:
      begin
        pin_drive_d = 1'b1;
        if (supply_ok)
        begin
          state_d = RPC_ST_POR_DELAY;
          delay_d = '0;
        end
      end
      RPC_ST_POR_DELAY:
      begin
        if (!supply_ok)
        begin
          state_d = RPC_ST_POWER_UP;
        end
        else if (delay_q == 32'(POR_DELAY_CYCLES - 1))
        begin
          // Power-on exit: flag set, monitor enabled, threshold low.
          state_d = RPC_ST_RUN;
          por_flag_d = 1'b1;
          mon_en_d = 1'b1;
          mon_sel_d = 1'b1;
          mon_lvl_d = 1'b0;
          pin_drive_d = 1'b0;
          cal_d = 1'b1;
        end
        else
        begin
          delay_d = delay_q + 32'd1;
        end
      end
      RPC_ST_RUN:
      begin
        if (any_reset)
        begin
          // Registers return to reset values; monitor enable and level survive.
          state_d = RPC_ST_HOLD;
          flags_d = '0;
          stop_d = 1'b0;
          idle_d = 1'b0;
          pin_drive_d = mon_reset;
          por_flag_d = 1'b0;
        end
        else
        begin
          if (sfr_write(sfr_req, RPC_ADDR_POWER_MODE))
          begin
            flags_d = sfr_req.wdata[7:RPC_BIT_FLAGS_LO];
            stop_d = stop_q | sfr_req.wdata[RPC_BIT_STOP];
            idle_d = idle_q | sfr_req.wdata[RPC_BIT_IDLE];
          end
          if (idle_q && enabled_interrupt)
          begin
            idle_d = 1'b0;
          end
          if (sfr_write(sfr_req, RPC_ADDR_RESET_SOURCE))
          begin
            mon_sel_d = sfr_req.wdata[RPC_BIT_POWER_ON_FLAG];
          end
          if (sfr_write(sfr_req, RPC_ADDR_MONITOR))
          begin
            mon_en_d = sfr_req.wdata[RPC_BIT_MON_ENABLE];
            mon_lvl_d = sfr_req.wdata[RPC_BIT_MON_LEVEL];
          end
          // A flash operation is unsafe unless the monitor guards the high threshold.
          if (flash_write_attempt && !(mon_en_q && mon_lvl_q))
          begin
            flash_err_d = 1'b1;
          end
        end
      end
      RPC_ST_HOLD:
      begin
        // An un-calibrated regulator can sit below the high threshold, so this may hold until power-on.
        if (!any_reset)
        begin
          state_d = RPC_ST_RUN;
          pin_drive_d = 1'b0;
          cal_d = 1'b1;
        end
        else
        begin
          pin_drive_d = pin_drive_q | mon_reset;
        end
      end
      default:
      begin
        state_d = RPC_ST_POWER_UP;
      end
    endcase
  end

  // Read data; request bits always read zero.
  always_comb
  begin
    rdata_d = rdata_q;
    if (sfr_req.rd)
    begin
      unique case (sfr_req.addr)
        RPC_ADDR_POWER_MODE: rdata_d = {flags_q, 2'b00};
        RPC_ADDR_RESET_SOURCE: rdata_d = {6'd0, por_flag_q, 1'b0};
        RPC_ADDR_MONITOR: rdata_d = {mon_en_q, supply_ok, mon_lvl_q, 5'd0};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Watchdog prescaler runs only outside reset.
  always_comb
  begin
    wdt_cnt_d = wdt_cnt_q;
    wdt_tick_d = 1'b0;
    if (!in_run)
    begin
      wdt_cnt_d = '0;
    end
    else if (wdt_cnt_q == 4'(RPC_WDT_DIVIDE - 1))
    begin
      wdt_cnt_d = '0;
      wdt_tick_d = 1'b1;
    end
    else
    begin
      wdt_cnt_d = wdt_cnt_q + 4'd1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= RPC_ST_POWER_UP;
      delay_q <= '0;
      flags_q <= RPC_POWER_MODE_RESET[7:2];
      stop_q <= 1'b0;
      idle_q <= 1'b0;
      por_flag_q <= 1'b0;
      mon_en_q <= 1'b0;
      mon_lvl_q <= 1'b0;
      mon_sel_q <= 1'b0;
      pin_drive_q <= 1'b1;
      flash_err_q <= 1'b0;
      rdata_q <= 8'h00;
      cal_q <= 1'b0;
      wdt_cnt_q <= '0;
      wdt_tick_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      delay_q <= delay_d;
      flags_q <= flags_d;
      stop_q <= stop_d;
      idle_q <= idle_d;
      por_flag_q <= por_flag_d;
      mon_en_q <= mon_en_d;
      mon_lvl_q <= mon_lvl_d;
      mon_sel_q <= mon_sel_d;
      pin_drive_q <= pin_drive_d;
      flash_err_q <= flash_err_d;
      rdata_q <= rdata_d;
      cal_q <= cal_d;
      wdt_cnt_q <= wdt_cnt_d;
      wdt_tick_q <= wdt_tick_d;
    end
  end

  // Outputs are registered or tied to constants; the control word is built from state_q, any_reset and the next-state idle_d and stop_d values.
  rpc_core_ctl_t ctl_q, ctl_d;
  logic [PORT_WIDTH-1:0] latch_q;
  logic force_q;

  always_comb
  begin
    ctl_d.core_reset = !in_run || any_reset;
    ctl_d.cpu_clk_gate = idle_d || stop_d;
    ctl_d.osc_halt = stop_d;
    ctl_d.periph_halt = stop_d;
    ctl_d.int_timer_disable = !in_run || stop_d;
    ctl_d.osc_select_internal = 1'b1;
    ctl_d.wdt_enable = in_run;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ctl_q <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
      latch_q <= '1;
      force_q <= 1'b1;
    end
    else
    begin
      ctl_q <= ctl_d;
      latch_q <= {PORT_WIDTH{1'b1}};
      force_q <= ctl_d.core_reset;
    end
  end

  assign core_ctl = ctl_q;
  assign sfr_rdata = rdata_q;
  // Stack pointer and registers are reset by core_reset; data memory has no reset path.
  assign pc_load_value = RPC_RESET_VECTOR;
  assign regulator_calibrate = cal_q;
  assign wdt_tick = wdt_tick_q;
  assign reset_pin_n_out = 1'b0;
  assign reset_pin_n_oe = pin_drive_q;
  assign port_latch_force = latch_q;
  assign port_force_en = force_q;
  assign port_weak_pullup_en = 1'b1;

endmodule

// *** hw/rpc_pkg.sv ***
// Purpose: Shared constants and types for the reset and power control block.
// Assumes: Registers are reached over the special function register port at their printed addresses.
// Notes: Timing counts assume the 200 MHz system clock.
package rpc_pkg;

  // Register addresses.
  localparam logic [7:0] RPC_ADDR_POWER_MODE = 8'h87;
  localparam logic [7:0] RPC_ADDR_RESET_SOURCE = 8'hef;
  localparam logic [7:0] RPC_ADDR_MONITOR = 8'hff;

  // Field positions.
  localparam int RPC_BIT_IDLE = 0;
  localparam int RPC_BIT_STOP = 1;
  localparam int RPC_BIT_FLAGS_LO = 2;
  localparam int RPC_BIT_POWER_ON_FLAG = 1;
  localparam int RPC_BIT_MON_ENABLE = 7;
  localparam int RPC_BIT_SUPPLY_STATUS = 6;
  localparam int RPC_BIT_MON_LEVEL = 5;

  // Reset values.
  localparam logic [7:0] RPC_POWER_MODE_RESET = 8'h00;
  localparam logic [7:0] RPC_PORT_LATCH_RESET = 8'hff;
  localparam logic [15:0] RPC_RESET_VECTOR = 16'h0000;

  // Timing.
  localparam int RPC_CLK_MHZ = 200;
  localparam int RPC_POR_DELAY_US = 100;
  localparam int RPC_POR_DELAY_CYCLES = RPC_POR_DELAY_US * RPC_CLK_MHZ;
  localparam int RPC_WDT_DIVIDE = 12;

  // Special function register access.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rpc_sfr_req_t;

  // Core control outputs.
  typedef struct packed {
    logic core_reset;
    logic cpu_clk_gate;
    logic osc_halt;
    logic periph_halt;
    logic int_timer_disable;
    logic osc_select_internal;
    logic wdt_enable;
  } rpc_core_ctl_t;

endpackage

// *** hw/rpc_sync.sv ***
// Purpose: Two-flop synchroniser for asynchronous reset source levels.
// Assumes: Inputs arrive from outside the clock domain.
// Notes: The first stage is read only by the second.
`timescale 1ns/1ps
module rpc_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// *** verification/rpc_supply_model.sv ***
// Purpose: Far-side model of the supply and the open-drain reset pin.
// Assumes: The reset pin has an external pull-up.
// Notes: Slow mode delays supply changes by three cycles.
`timescale 1ns/1ps
module rpc_supply_model (
  // Clock
  input wire logic clk,
  // Bench commands
  input wire logic supply_cmd,
  input wire logic slow,
  // Pin and supply
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic supply_ok,
  output logic pin_level
);
  logic [2:0] dly_q;
  always_ff @(posedge clk)
  begin
    dly_q <= {dly_q[1:0], supply_cmd};
  end
  // An undriven pin floats up to the pull-up, never to its last value.
  assign pin_level = pin_oe ? pin_out : 1'b1;
  assign supply_ok = slow ? dly_q[2] : supply_cmd;
endmodule

// *** verification/rpc_top_asserts.sv ***
// Purpose: Port-level checks of the reset and power control block.
// Assumes: Reset sources are held long enough to pass the synchroniser.
// Notes: Bound to every rpc_top instance.
`timescale 1ns/1ps
module rpc_top_asserts
  import rpc_pkg::*;
#(
  parameter int POR_DELAY_CYCLES = 8,
  parameter int PORT_WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire rpc_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  // Sources and events
  input wire logic supply_above_threshold,
  input wire logic other_reset_req,
  input wire logic software_reset_req,
  input wire logic enabled_interrupt,
  input wire logic flash_write_attempt,
  // Core side
  input wire rpc_core_ctl_t core_ctl,
  input wire logic [15:0] pc_load_value,
  input wire logic regulator_calibrate,
  input wire logic wdt_tick,
  input wire logic reset_pin_n_out,
  input wire logic reset_pin_n_oe,
  input wire logic [PORT_WIDTH-1:0] port_latch_force,
  input wire logic port_force_en,
  input wire logic port_weak_pullup_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence pm_write;
    sfr_req.wr && sfr_req.addr == RPC_ADDR_POWER_MODE && !core_ctl.core_reset;
  endsequence
  sequence reset_exit;
    core_ctl.core_reset ##1 !core_ctl.core_reset;
  endsequence
  por_hold_a: assert property ($fell(reset) |-> core_ctl.core_reset && reset_pin_n_oe)
    else $error("power-up not held");
  pin_low_a: assert property (reset_pin_n_oe |-> !reset_pin_n_out && core_ctl.core_reset)
    else $error("pin not driven low");
  port_force_a: assert property (port_force_en |-> port_latch_force == '1 && port_weak_pullup_en)
    else $error("port default wrong");
  exit_vector_a: assert property (reset_exit |-> pc_load_value == RPC_RESET_VECTOR && core_ctl.wdt_enable
    && core_ctl.osc_select_internal)
    else $error("reset exit state wrong");
  calib_exit_a: assert property (reset_exit |-> $past(regulator_calibrate))
    else $error("no calibrate before reset exit");
  idle_set_a: assert property (pm_write ##0 sfr_req.wdata[0] && !enabled_interrupt |=> core_ctl.cpu_clk_gate
    && !core_ctl.osc_halt)
    else $error("idle not entered");
  stop_set_a: assert property (pm_write ##0 sfr_req.wdata[1] |=> core_ctl.osc_halt)
    else $error("stop not entered");
  read_zero_a: assert property (sfr_req.rd && sfr_req.addr == RPC_ADDR_POWER_MODE |=> sfr_rdata[1:0] == 2'b00)
    else $error("mode bits read nonzero");
  idle_wake_a: assert property (core_ctl.cpu_clk_gate && !core_ctl.osc_halt && enabled_interrupt |=> !core_ctl.cpu_clk_gate)
    else $error("idle not woken");
  mode_clear_a: assert property ($rose(core_ctl.core_reset) |-> ##1 !core_ctl.osc_halt && !core_ctl.cpu_clk_gate)
    else $error("mode kept over reset");
  calib_pulse_a: assert property (regulator_calibrate |=> !regulator_calibrate)
    else $error("calibrate pulse long");
  wdt_gap_a: assert property (wdt_tick |=> !wdt_tick [*8])
    else $error("watchdog tick too soon");
  source_a: assert property (other_reset_req |-> ##[1:6] core_ctl.core_reset)
    else $error("source not combined");
endmodule
bind rpc_top rpc_top_asserts #(.POR_DELAY_CYCLES(POR_DELAY_CYCLES), .PORT_WIDTH(PORT_WIDTH)) u_asserts (
  .clk(clk), .reset(reset), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .supply_above_threshold(supply_above_threshold), .other_reset_req(other_reset_req),
  .software_reset_req(software_reset_req), .enabled_interrupt(enabled_interrupt),
  .flash_write_attempt(flash_write_attempt), .core_ctl(core_ctl), .pc_load_value(pc_load_value),
  .regulator_calibrate(regulator_calibrate), .wdt_tick(wdt_tick), .reset_pin_n_out(reset_pin_n_out),
  .reset_pin_n_oe(reset_pin_n_oe), .port_latch_force(port_latch_force), .port_force_en(port_force_en),
  .port_weak_pullup_en(port_weak_pullup_en));

// *** verification/test_reset_and_power_control.sv ***
// Purpose: Self-checking bench for the reset and power control block.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: The power-on delay is cut to 8 cycles.
`timescale 1ns/1ps
module test_reset_and_power_control;
  import rpc_pkg::*;
  logic clk = 0;
  logic reset = 1;
  rpc_sfr_req_t sfr_req = '0;
  logic [7:0] sfr_rdata, pf, v;
  logic supply_cmd = 0, slow = 0, supply_ok, pin_level;
  logic other_req = 0, sw_req = 0, irq = 0, flash = 0;
  rpc_core_ctl_t ctl;
  logic [15:0] pc;
  logic cal, tick, pin_out, pin_oe, pf_en, wpu;
  int bad_count = 0, compares = 0, n;
  always #2.5 clk = ~clk;
  rpc_top #(.POR_DELAY_CYCLES(8)) u_dut (.clk(clk), .reset(reset), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .supply_above_threshold(supply_ok), .other_reset_req(other_req), .software_reset_req(sw_req),
    .enabled_interrupt(irq), .flash_write_attempt(flash), .core_ctl(ctl), .pc_load_value(pc),
    .regulator_calibrate(cal), .wdt_tick(tick), .reset_pin_n_out(pin_out), .reset_pin_n_oe(pin_oe),
    .port_latch_force(pf), .port_force_en(pf_en), .port_weak_pullup_en(wpu));
  rpc_supply_model u_model (.clk(clk), .supply_cmd(supply_cmd), .slow(slow), .pin_out(pin_out),
    .pin_oe(pin_oe), .supply_ok(supply_ok), .pin_level(pin_level));
  task print_verdict;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task step(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task chk_bit(string what, logic exp, logic got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask
  task chk_byte(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // The idle cycle after each write keeps back-to-back calls from retoggling wr in one step.
  task wr(logic [7:0] a, logic [7:0] d);
    sfr_req = {1'b1, 1'b0, a, d};
    step(1);
    sfr_req = '0;
    step(1);
  endtask
  task rd(logic [7:0] a);
    sfr_req = {1'b0, 1'b1, a, 8'h00};
    step(1);
    sfr_req.rd = 0;
    step(1);
    v = sfr_rdata;
  endtask
  task pulse_flash;
    flash = 1;
    step(1);
    flash = 0;
  endtask
  task wait_core(logic lvl, int lim);
    n = 0;
    while (ctl.core_reset !== lvl && n < lim)
    begin
      step(1);
      n++;
    end
    chk_bit("core reset", lvl, ctl.core_reset);
  endtask
  initial
  begin
    step(12);
    reset = 0;
    step(20);
    chk_bit("power-up hold", 1'b1, ctl.core_reset);
    chk_bit("pin low", 1'b0, pin_level);
    chk_byte("port latch", 8'hff, pf);
    chk_bit("pullup", 1'b1, wpu);
    chk_bit("port force", 1'b1, pf_en);
    chk_bit("timers off", 1'b1, ctl.int_timer_disable);
    supply_cmd = 1;
    wait_core(1'b0, 40);
    chk_bit("power-on delay", 1'b1, n >= 8);
    chk_bit("pin released", 1'b1, pin_level);
    chk_bit("internal osc", 1'b1, ctl.osc_select_internal);
    rd(RPC_ADDR_POWER_MODE);
    chk_byte("mode reset", 8'h00, v);
    rd(RPC_ADDR_RESET_SOURCE);
    chk_bit("power-on flag", 1'b1, v[1]);
    rd(RPC_ADDR_MONITOR);
    chk_byte("monitor reg", 8'hc0, v);
    n = 0;
    repeat (36)
    begin
      step(1);
      n += tick;
    end
    chk_bit("watchdog ticks", 1'b1, n == 3);
    wr(RPC_ADDR_POWER_MODE, 8'hfd);
    chk_bit("cpu gated", 1'b1, ctl.cpu_clk_gate);
    chk_bit("osc runs", 1'b0, ctl.osc_halt);
    rd(RPC_ADDR_POWER_MODE);
    chk_byte("flags", 8'hfc, v);
    irq = 1;
    step(1);
    irq = 0;
    chk_bit("idle wake", 1'b0, ctl.cpu_clk_gate);
    pulse_flash;
    wait_core(1'b1, 4);
    wait_core(1'b0, 40);
    rd(RPC_ADDR_POWER_MODE);
    chk_byte("flags cleared", 8'h00, v);
    rd(RPC_ADDR_RESET_SOURCE);
    chk_bit("flag cleared", 1'b0, v[1]);
    rd(RPC_ADDR_MONITOR);
    chk_bit("monitor kept on", 1'b1, v[7]);
    wr(RPC_ADDR_MONITOR, 8'h00);
    sw_req = 1;
    wait_core(1'b1, 6);
    sw_req = 0;
    wait_core(1'b0, 40);
    rd(RPC_ADDR_MONITOR);
    chk_bit("monitor kept off", 1'b0, v[7]);
    wr(RPC_ADDR_MONITOR, 8'h80);
    wr(RPC_ADDR_MONITOR, 8'ha0);
    wr(RPC_ADDR_RESET_SOURCE, 8'h02);
    pulse_flash;
    step(6);
    chk_bit("protected write", 1'b0, ctl.core_reset);
    wr(RPC_ADDR_MONITOR, 8'h80);
    slow = 1;
    supply_cmd = 0;
    wait_core(1'b1, 10);
    chk_bit("pin monitor", 1'b0, pin_level);
    slow = 0;
    step(3);
    chk_bit("monitor hold", 1'b1, ctl.core_reset);
    chk_bit("pin held", 1'b0, pin_level);
    supply_cmd = 1;
    wait_core(1'b0, 7);
    wr(RPC_ADDR_POWER_MODE, 8'h02);
    chk_bit("stop", 1'b1, ctl.osc_halt);
    chk_bit("periph halt", 1'b1, ctl.periph_halt);
    irq = 1;
    step(2);
    chk_bit("stop stays", 1'b1, ctl.osc_halt);
    irq = 0;
    other_req = 1;
    wait_core(1'b1, 6);
    other_req = 0;
    wait_core(1'b0, 40);
    chk_bit("stop left", 1'b0, ctl.osc_halt);
    print_verdict;
  end
  initial
  begin
    #20000;
    bad_count++;
    print_verdict;
  end
endmodule
